// *** rtl/cpc_pkg.sv ***
// Constants and types shared by the camera parameter command handler.
package cpc_pkg;
   // -----------------------------------------------------------------
   // Framing bytes
   // -----------------------------------------------------------------
   localparam logic [7:0] CPC_START_BYTE = 8'h02;
   localparam logic [7:0] CPC_END_BYTE = 8'h03;
   localparam logic [7:0] CPC_ACK_BYTE = 8'h06;
   localparam logic [7:0] CPC_NAK_BYTE = 8'h15;
   // -----------------------------------------------------------------
   // Command identifiers and payload lengths
   // -----------------------------------------------------------------
   localparam logic [7:0] CPC_ID_OUTPUT_MODE = 8'hC0;
   localparam logic [7:0] CPC_ID_EXPOSURE_MODE = 8'hA0;
   localparam logic [7:0] CPC_ID_TIMER1 = 8'hA6;
   localparam logic [6:0] CPC_LEN_MODE = 7'h01;
   localparam logic [6:0] CPC_LEN_TIMER1 = 7'h03;
   // -----------------------------------------------------------------
   // Mode codes
   // -----------------------------------------------------------------
   localparam logic [7:0] CPC_OUT_SINGLE8 = 8'h00;
   localparam logic [7:0] CPC_OUT_DUAL8 = 8'h01;
   localparam logic [7:0] CPC_OUT_SINGLE10 = 8'h02;
   localparam logic [7:0] CPC_OUT_DUAL10 = 8'h03;
   localparam logic [7:0] CPC_EXP_FREE_PROG = 8'h00;
   localparam logic [7:0] CPC_EXP_TRIG_LEVEL = 8'h04;
   localparam logic [7:0] CPC_EXP_TRIG_PROG = 8'h05;
   // -----------------------------------------------------------------
   // Values after reset
   // -----------------------------------------------------------------
   localparam logic [7:0] CPC_OUT_MODE_RST = 8'h00;
   localparam logic [7:0] CPC_EXP_MODE_RST = 8'h00;
   localparam logic [23:0] CPC_TIMER1_RST = 24'h0003E8;
   // -----------------------------------------------------------------
   // Reply buffer: acknowledge plus the longest response frame
   // -----------------------------------------------------------------
   localparam int CPC_TX_DEPTH = 9;
   localparam logic [3:0] CPC_TX_ACK_ONLY = 4'h1;
   localparam logic [3:0] CPC_TX_MODE_LEN = 4'h7;
   localparam logic [3:0] CPC_TX_TIMER_LEN = 4'h9;

   typedef struct packed
   {
      logic [7:0] outputMode;
      logic [7:0] exposureMode;
      logic [23:0] timer1;
   } cpc_param_type;

   typedef enum logic [2:0]
   {
      CPC_ST_IDLE,
      CPC_ST_ID,
      CPC_ST_FLAG,
      CPC_ST_DATA,
      CPC_ST_CHECK,
      CPC_ST_END,
      CPC_ST_SEND
   } cpc_state_type;
endpackage

// *** rtl/cpc_command_handler.sv ***
// Parameter command interpreter for the camera serial command link.
// Notes on behaviour
// - Output mode parameter is read and written under identifier C0, one byte.
// - Output mode codes 00..03: single/dual channel, 8 or 10 bit.
// - Exposure mode parameter is read and written under identifier A0, one byte.
// - Exposure codes 00 free-run, 04 trigger level, 05 trigger programmable.
// - First exposure timer is read and written under identifier A6, three bytes.
// - Timer bytes travel low byte first, then middle, then high.
// - Timer sets exposure only in free-run or trigger programmable mode.
// - Reads carry flag 1, no payload; answer has flag 0 and payload.
// - Descriptor is identifier byte, then read flag bit, then 7-bit length.
// - Frame is start 02, descriptor, payload, XOR check byte, end 03.
// - Device replies 06 when order, check byte and length agree, else 15.
// - Written values are stored without range or code checks.
module cpc_command_handler
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Received byte stream from the link
   input wire logic [7:0] rxByte,
   input wire logic rxValid,
   output logic rxReady,
   // Transmitted byte stream to the link
   output logic [7:0] txByte,
   output logic txValid,
   input wire logic txReady,
   // Parameter values and their decoded meaning
   output cpc_pkg::cpc_param_type param,
   output logic dualChannel,
   output logic tenBit,
   output logic externalLineTrigger,
   output logic levelControlled,
   output logic timer1Use
);
   // -----------------------------------------------------------------
   // Reset release
   // -----------------------------------------------------------------
   logic rstMeta_q;
   logic rstSync_q;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end
      else
      begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   // -----------------------------------------------------------------
   // Frame reception
   // -----------------------------------------------------------------
   cpc_pkg::cpc_state_type state_q;
   logic [7:0] cmdId_q;
   logic readFlag_q;
   logic [6:0] len_q;
   logic [6:0] cnt_q;
   logic [7:0] bcc_q;
   logic [7:0] rxBcc_q;
   logic [23:0] payload_q;
   logic [3:0] txLen_q;
   logic [3:0] txIdx_q;
   logic [7:0] txBuf_q [0:cpc_pkg::CPC_TX_DEPTH-1];
   cpc_pkg::cpc_param_type param_q;
   logic rxTake;
   logic txTake;
   logic frameGood;
   logic knownLen;
   logic [23:0] readValue;
   logic [7:0] respBcc;

   assign rxReady = (state_q != cpc_pkg::CPC_ST_SEND);
   assign rxTake = rxValid && rxReady;
   assign txValid = (state_q == cpc_pkg::CPC_ST_SEND);
   assign txTake = txValid && txReady;
   assign txByte = txBuf_q[txIdx_q];
   // A long frame hits the end check early, so order and length
   // errors both surface as a missing end byte here.
   assign frameGood = (rxByte == cpc_pkg::CPC_END_BYTE)
      && (rxBcc_q == bcc_q);

   always_ff @(posedge clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
      begin
         state_q <= cpc_pkg::CPC_ST_IDLE;
         cmdId_q <= 8'h00;
         readFlag_q <= 1'b0;
         len_q <= 7'h00;
         cnt_q <= 7'h00;
         bcc_q <= 8'h00;
         rxBcc_q <= 8'h00;
         payload_q <= 24'h000000;
      end
      else
      begin
         unique case (state_q)
            cpc_pkg::CPC_ST_IDLE:
               if (rxTake && rxByte == cpc_pkg::CPC_START_BYTE)
               begin
                  state_q <= cpc_pkg::CPC_ST_ID;
                  cnt_q <= 7'h00;
                  payload_q <= 24'h000000;
               end
            cpc_pkg::CPC_ST_ID:
               if (rxTake)
               begin
                  cmdId_q <= rxByte;
                  bcc_q <= rxByte;
                  state_q <= cpc_pkg::CPC_ST_FLAG;
               end
            cpc_pkg::CPC_ST_FLAG:
               if (rxTake)
               begin
                  readFlag_q <= rxByte[7];
                  len_q <= rxByte[6:0];
                  bcc_q <= bcc_q ^ rxByte;
                  // Reads carry no payload whatever the length says.
                  if (!rxByte[7] && rxByte[6:0] != 7'h00)
                     state_q <= cpc_pkg::CPC_ST_DATA;
                  else
                     state_q <= cpc_pkg::CPC_ST_CHECK;
               end
            cpc_pkg::CPC_ST_DATA:
               if (rxTake)
               begin
                  if (cnt_q < 7'h03)
                     payload_q[cnt_q[1:0]*8 +: 8] <= rxByte;
                  bcc_q <= bcc_q ^ rxByte;
                  cnt_q <= cnt_q + 7'h01;
                  if (cnt_q == len_q - 7'h01)
                     state_q <= cpc_pkg::CPC_ST_CHECK;
               end
            cpc_pkg::CPC_ST_CHECK:
               if (rxTake)
               begin
                  rxBcc_q <= rxByte;
                  state_q <= cpc_pkg::CPC_ST_END;
               end
            cpc_pkg::CPC_ST_END:
               if (rxTake)
                  state_q <= cpc_pkg::CPC_ST_SEND;
            cpc_pkg::CPC_ST_SEND:
               if (txTake && txIdx_q == txLen_q - 4'h1)
                  state_q <= cpc_pkg::CPC_ST_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Command decode
   // -----------------------------------------------------------------
   always_comb
   begin
      knownLen = 1'b0;
      readValue = 24'h000000;
      unique case (cmdId_q)
         cpc_pkg::CPC_ID_OUTPUT_MODE:
         begin
            knownLen = (len_q == cpc_pkg::CPC_LEN_MODE);
            readValue = {16'h0000, param_q.outputMode};
         end
         cpc_pkg::CPC_ID_EXPOSURE_MODE:
         begin
            knownLen = (len_q == cpc_pkg::CPC_LEN_MODE);
            readValue = {16'h0000, param_q.exposureMode};
         end
         cpc_pkg::CPC_ID_TIMER1:
         begin
            knownLen = (len_q == cpc_pkg::CPC_LEN_TIMER1);
            readValue = param_q.timer1;
         end
         default:
         begin
            knownLen = 1'b0;
            readValue = 24'h000000;
         end
      endcase
      respBcc = cmdId_q ^ {1'b0, len_q} ^ readValue[7:0]
         ^ readValue[15:8] ^ readValue[23:16];
   end

   // -----------------------------------------------------------------
   // Parameter storage
   // -----------------------------------------------------------------
   // Values go in unchecked, so an illegal code is stored and read back.
   always_ff @(posedge clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
      begin
         param_q.outputMode <= cpc_pkg::CPC_OUT_MODE_RST;
         param_q.exposureMode <= cpc_pkg::CPC_EXP_MODE_RST;
         param_q.timer1 <= cpc_pkg::CPC_TIMER1_RST;
      end
      else if (state_q == cpc_pkg::CPC_ST_END && rxTake && frameGood
         && !readFlag_q && knownLen)
      begin
         if (cmdId_q == cpc_pkg::CPC_ID_OUTPUT_MODE)
            param_q.outputMode <= payload_q[7:0];
         if (cmdId_q == cpc_pkg::CPC_ID_EXPOSURE_MODE)
            param_q.exposureMode <= payload_q[7:0];
         if (cmdId_q == cpc_pkg::CPC_ID_TIMER1)
            param_q.timer1 <= payload_q;
      end
   end

   // -----------------------------------------------------------------
   // Reply assembly and transmission
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
      begin
         txLen_q <= 4'h0;
         txIdx_q <= 4'h0;
         for (int i = 0; i < cpc_pkg::CPC_TX_DEPTH; i++)
            txBuf_q[i] <= 8'h00;
      end
      else if (state_q == cpc_pkg::CPC_ST_END && rxTake)
      begin
         txIdx_q <= 4'h0;
         txLen_q <= cpc_pkg::CPC_TX_ACK_ONLY;
         txBuf_q[0] <= frameGood ? cpc_pkg::CPC_ACK_BYTE
            : cpc_pkg::CPC_NAK_BYTE;
         // Unknown reads are acknowledged but get no frame.
         if (frameGood && readFlag_q && knownLen)
         begin
            txBuf_q[1] <= cpc_pkg::CPC_START_BYTE;
            txBuf_q[2] <= cmdId_q;
            txBuf_q[3] <= {1'b0, len_q};
            txBuf_q[4] <= readValue[7:0];
            if (len_q == cpc_pkg::CPC_LEN_TIMER1)
            begin
               txBuf_q[5] <= readValue[15:8];
               txBuf_q[6] <= readValue[23:16];
               txBuf_q[7] <= respBcc;
               txBuf_q[8] <= cpc_pkg::CPC_END_BYTE;
               txLen_q <= cpc_pkg::CPC_TX_TIMER_LEN;
            end
            else
            begin
               txBuf_q[5] <= respBcc;
               txBuf_q[6] <= cpc_pkg::CPC_END_BYTE;
               txLen_q <= cpc_pkg::CPC_TX_MODE_LEN;
            end
         end
      end
      else if (txTake)
         txIdx_q <= txIdx_q + 4'h1;
   end

   // -----------------------------------------------------------------
   // Mode decode
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
      begin
         dualChannel <= 1'b0;
         tenBit <= 1'b0;
         externalLineTrigger <= 1'b0;
         levelControlled <= 1'b0;
         timer1Use <= 1'b0;
      end
      else
      begin
         dualChannel <= (param_q.outputMode == cpc_pkg::CPC_OUT_DUAL8)
            || (param_q.outputMode == cpc_pkg::CPC_OUT_DUAL10);
         tenBit <= (param_q.outputMode == cpc_pkg::CPC_OUT_SINGLE10)
            || (param_q.outputMode == cpc_pkg::CPC_OUT_DUAL10);
         externalLineTrigger <=
            (param_q.exposureMode == cpc_pkg::CPC_EXP_TRIG_LEVEL)
            || (param_q.exposureMode == cpc_pkg::CPC_EXP_TRIG_PROG);
         levelControlled <=
            (param_q.exposureMode == cpc_pkg::CPC_EXP_TRIG_LEVEL);
         timer1Use <=
            (param_q.exposureMode == cpc_pkg::CPC_EXP_FREE_PROG)
            || (param_q.exposureMode == cpc_pkg::CPC_EXP_TRIG_PROG);
      end
   end

   assign param = param_q;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstSync_q);

   logic endTake;
   assign endTake = (state_q == cpc_pkg::CPC_ST_END) && rxTake;

   reply_first_a: assert property (endTake |=> txValid
      && txByte == ($past(frameGood) ? cpc_pkg::CPC_ACK_BYTE
      : cpc_pkg::CPC_NAK_BYTE))
      else $error("reply does not open with ack or nak");
   nak_alone_a: assert property ($rose(txValid) && txByte == 8'h15
      |-> txLen_q == 4'h1)
      else $error("nak followed by a frame");
   bad_check_a: assert property (endTake && rxBcc_q != bcc_q
      |=> txValid && txByte == 8'h15)
      else $error("bad check byte not refused");
   mode_write_a: assert property (endTake && frameGood && !readFlag_q
      && knownLen && cmdId_q == 8'hC0
      |=> param.outputMode == $past(payload_q[7:0]))
      else $error("output mode write lost");
   timer_write_a: assert property (endTake && frameGood && !readFlag_q
      && cmdId_q == 8'hA6 && len_q == 7'h03
      |=> param.timer1 == $past(payload_q))
      else $error("timer write misordered");
   read_stable_a: assert property (endTake && readFlag_q
      |=> $stable(param))
      else $error("read changed a parameter");
   resp_frame_a: assert property ($rose(txValid) && txLen_q > 4'h1
      |-> txBuf_q[1] == 8'h02
      && txBuf_q[3] == (txLen_q == 4'h9 ? 8'h03 : 8'h01)
      && txBuf_q[txLen_q - 4'h1] == 8'h03)
      else $error("response frame malformed");
   timer_resp_a: assert property ($rose(txValid) && txLen_q == 4'h9
      |-> txBuf_q[2] == 8'hA6 && txBuf_q[4] == param.timer1[7:0]
      && txBuf_q[6] == param.timer1[23:16])
      else $error("timer read answer wrong");
   mode_bcc_a: assert property ($rose(txValid) && txLen_q == 4'h7
      |-> txBuf_q[5] == (txBuf_q[2] ^ txBuf_q[3] ^ txBuf_q[4]))
      else $error("mode answer check byte wrong");
   level_mode_a: assert property (param.exposureMode == 8'h04
      |=> !timer1Use && levelControlled)
      else $error("timer used in level mode");
   dual_ten_a: assert property (param.outputMode == 8'h03
      |=> dualChannel && tenBit)
      else $error("dual 10 bit decode wrong");
   hold_rx_a: assert property (txValid && !txReady |=>
      $stable(txByte) && !rxReady)
      else $error("reply byte moved while stalled");

   write_seen_c: cover property (endTake && frameGood && !readFlag_q
      && cmdId_q == 8'hA6);
   read_seen_c: cover property ($rose(txValid) && txLen_q == 4'h7);
   nak_seen_c: cover property ($rose(txValid) && txByte == 8'h15);
   unknown_c: cover property (endTake && frameGood && !knownLen);
endmodule

// *** verif/cpc_host_model.sv ***
// Host computer model that frames parameter commands and collects replies.
module cpc_host_model
(
   // Clock
   input wire logic clk,
   // Byte stream into the handler
   output logic [7:0] rxByte,
   output logic rxValid,
   input wire logic rxReady,
   // Byte stream out of the handler
   input wire logic [7:0] txByte,
   input wire logic txValid,
   output logic txReady
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] replies[$];
   integer seed = 32'h63e99dfa;

   initial
   begin
      rxByte = 8'h00;
      rxValid = 1'b0;
      txReady = 1'b0;
   end

   // -----------------------------------------------------------------
   // Reply sink
   // -----------------------------------------------------------------
   // The sink stalls at random so that the handler must hold each byte.
   always @(negedge clk)
      txReady <= |($random(seed) & 3);

   always @(posedge clk)
      if (txValid && txReady)
         replies.push_back(txByte);

   // -----------------------------------------------------------------
   // Command framing
   // -----------------------------------------------------------------
   // Called at a falling edge; returns at the falling edge after the take.
   task automatic send_byte(input logic [7:0] b);
      rxByte = b;
      rxValid = 1'b1;
      while (rxReady !== 1'b1)
         @(negedge clk);
      @(posedge clk);
      @(negedge clk);
   endtask

   task automatic send_frame(input logic [7:0] id, input logic [7:0] fl,
                             input int n, input logic [23:0] d,
                             input logic [7:0] chkx, input logic [7:0] endb);
      logic [7:0] chk;
      chk = id ^ fl;
      send_byte(cpc_pkg::CPC_START_BYTE);
      send_byte(id);
      send_byte(fl);
      for (int i = 0; i < n; i++)
      begin
         send_byte(d[8*i+:8]);
         chk = chk ^ d[8*i+:8];
      end
      send_byte(chk ^ chkx);
      send_byte(endb);
      // A released line shows the inverse so a stale byte is never reused.
      rxValid = 1'b0;
      rxByte = ~endb;
   endtask
endmodule

// *** verif/cpc_command_handler_tb.sv ***
// Self-checking testbench of the camera parameter command handler.
`define CHK(a, b) \
   begin \
      samples_checked++; \
      if ((a) !== (b)) \
      begin \
         failures++; \
         $display("[ERR] %0t got %h exp %h", $time, (a), (b)); \
      end \
   end

module cpc_command_handler_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] rxByte;
   logic [7:0] txByte;
   logic rxValid, rxReady, txValid, txReady;
   logic dualChannel, tenBit, externalLineTrigger, levelControlled;
   logic timer1Use;
   cpc_pkg::cpc_param_type param;
   cpc_pkg::cpc_param_type shadow;
   int failures = 0;
   int samples_checked = 0;
   integer seed = 32'h63e99dfa;
   logic [7:0] expq[$];
   logic [7:0] outCodes[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h7F};
   logic [7:0] expCodes[4] = '{8'h00, 8'h04, 8'h05, 8'h07};
   logic [23:0] v;

   always #2 clk = ~clk;

   cpc_command_handler dut
   (
      .clk(clk), .rst_b(rst_b),
      .rxByte(rxByte), .rxValid(rxValid), .rxReady(rxReady),
      .txByte(txByte), .txValid(txValid), .txReady(txReady),
      .param(param), .dualChannel(dualChannel), .tenBit(tenBit),
      .externalLineTrigger(externalLineTrigger),
      .levelControlled(levelControlled), .timer1Use(timer1Use)
   );

   cpc_host_model host
   (
      .clk(clk), .rxByte(rxByte), .rxValid(rxValid), .rxReady(rxReady),
      .txByte(txByte), .txValid(txValid), .txReady(txReady)
   );

   task print_verdict;
      if (failures == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // One command and the comparison of its whole reply
   // -----------------------------------------------------------------
   task automatic xact(input logic [7:0] id, input logic [7:0] fl,
                       input int n, input logic [23:0] d,
                       input logic [7:0] ack, input int rn,
                       input logic [7:0] chkx = 8'h00,
                       input logic [7:0] endb = cpc_pkg::CPC_END_BYTE);
      logic [7:0] chk;
      int t;
      expq = {ack};
      if (rn > 0)
      begin
         chk = id ^ 8'(rn);
         expq.push_back(cpc_pkg::CPC_START_BYTE);
         expq.push_back(id);
         expq.push_back(8'(rn));
         for (int i = 0; i < rn; i++)
         begin
            expq.push_back(d[8*i+:8]);
            chk = chk ^ d[8*i+:8];
         end
         expq.push_back(chk);
         expq.push_back(cpc_pkg::CPC_END_BYTE);
      end
      host.replies.delete();
      host.send_frame(id, fl, n, d, chkx, endb);
      t = 0;
      while ((host.replies.size() < expq.size() || rxReady !== 1'b1)
             && t < 300)
      begin
         @(negedge clk);
         t++;
      end
      `CHK(host.replies.size(), expq.size())
      foreach (expq[i])
         if (i < host.replies.size())
            `CHK(host.replies[i], expq[i])
   endtask

   task automatic check_param;
      logic [7:0] om;
      logic [7:0] em;
      om = shadow.outputMode;
      em = shadow.exposureMode;
      `CHK(param, shadow)
      `CHK(dualChannel, (om == 8'h01 || om == 8'h03))
      `CHK(tenBit, (om == 8'h02 || om == 8'h03))
      `CHK(externalLineTrigger, (em == 8'h04 || em == 8'h05))
      `CHK(levelControlled, (em == 8'h04))
      `CHK(timer1Use, (em == 8'h00 || em == 8'h05))
   endtask

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial
   begin
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      shadow = '{cpc_pkg::CPC_OUT_MODE_RST, cpc_pkg::CPC_EXP_MODE_RST,
                 cpc_pkg::CPC_TIMER1_RST};
      check_param;
      // A stray byte outside a frame must be dropped.
      host.send_byte(8'h55);
      foreach (outCodes[i])
      begin
         xact(8'hC0, 8'h01, 1, outCodes[i], 8'h06, 0);
         shadow.outputMode = outCodes[i];
         check_param;
         xact(8'hC0, 8'h81, 0, outCodes[i], 8'h06, 1);
      end
      foreach (expCodes[i])
      begin
         xact(8'hA0, 8'h01, 1, expCodes[i], 8'h06, 0);
         shadow.exposureMode = expCodes[i];
         check_param;
         xact(8'hA0, 8'h81, 0, expCodes[i], 8'h06, 1);
      end
      for (int k = 0; k < 6; k++)
      begin
         v = 24'($random(seed));
         if (k == 0)
            v = 24'h000001;
         if (k == 1)
            v = 24'hFFFFFF;
         if (v == 24'h000000)
            v = 24'h000001;
         xact(8'hA6, 8'h03, 3, v, 8'h06, 0);
         shadow.timer1 = v;
         check_param;
         xact(8'hA6, 8'h83, 0, v, 8'h06, 3);
      end
      // Faulty frames, unknown identifiers and wrong lengths write nothing.
      xact(8'hC0, 8'h01, 1, 24'h00005A, 8'h15, 0, 8'h01);
      xact(8'hC0, 8'h01, 1, 24'h00005A, 8'h15, 0, 8'h00, 8'h04);
      xact(8'h77, 8'h01, 1, 24'h00005A, 8'h06, 0);
      // One payload byte too many pushes the end byte out of place.
      xact(8'hC0, 8'h01, 2, 24'h00A55A, 8'h15, 0);
      xact(8'hA6, 8'h02, 2, 24'h005A5A, 8'h06, 0);
      xact(8'h77, 8'h81, 0, 24'h000000, 8'h06, 0);
      xact(8'hA6, 8'h81, 0, 24'h000000, 8'h06, 0);
      check_param;
      // A second reset in mid-run must bring every parameter back.
      rst_b = 1'b0;
      @(negedge clk);
      `CHK(txValid, 1'b0)
      `CHK(rxReady, 1'b1)
      @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      shadow = '{cpc_pkg::CPC_OUT_MODE_RST, cpc_pkg::CPC_EXP_MODE_RST,
                 cpc_pkg::CPC_TIMER1_RST};
      check_param;
      xact(8'hC0, 8'h01, 1, 24'h000002, 8'h06, 0);
      shadow.outputMode = 8'h02;
      check_param;
      print_verdict;
   end

   initial
   begin
      #100000;
      failures++;
      print_verdict;
   end
endmodule
